/* design/plme_pkg.sv */
// Behaviour
// - Pointer load writes a 12-bit literal into pointer 0, 1 or 2.
// - Pointer load is two words, opcode 1110111000 then 11110000; no flags.
// - Pointer load: high bits in Q4 of cycle one, low byte in Q4 of two.
// - File move reads a bank register; d=0 writes W, d=1 writes back.
// - Access bit 0 uses the access bank; access bit 1 uses bank select.
// - Extended set, access bit 0 and f at most 5Fh uses pointer-2 indexing.
// - File-to-file move copies any 12-bit source to any 12-bit destination.
// - File-to-file move accepts W's location as source or destination.
// - File-to-file: read source in Q2, no dummy read, write dest in Q4.
// - File-to-file words: 1100 plus source, then 1111 plus destination.
package plme_pkg;
    // Quarter phases of one instruction cycle
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;
    localparam logic [9:0] LF_OPC1 = 10'h3b8;
    localparam logic [7:0] LF_OPC2 = 8'hf0;
    localparam logic [5:0] MV_OPC = 6'h14;
    localparam logic [3:0] FF_OPC1 = 4'hc;
    localparam logic [3:0] FF_OPC2 = 4'hf;
    localparam logic [1:0] PTR_SEL_BAD = 2'h3;
    localparam logic [7:0] ACC_SPLIT = 8'h80;
    localparam logic [7:0] IDX_MAX = 8'h5f;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [3:0] ACC_HI_BANK = 4'hf;
    localparam logic [11:0] WREG_ADDR = 12'hffe;
    localparam logic [11:0] PTR_RST = 12'h000;
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic [11:0] ADDR_RST = 12'h000;
    localparam logic [7:0] DATA_RST = 8'h00;
    typedef enum logic [2:0] {
        ST_IDLE, ST_LF1, ST_LF2, ST_MV, ST_FF1, ST_FF2
    } plme_state_e;
endpackage

/* design/plme_ptr_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface plme_ptr_if;
    logic wr_hi;
    logic wr_lo;
    logic [1:0] sel;
    logic [7:0] wdata;
    logic [11:0] ptr [3];
    modport ctl (output wr_hi, output wr_lo, output sel, output wdata,
                 input ptr);
    modport regs (input wr_hi, input wr_lo, input sel, input wdata,
                  output ptr);
endinterface
`default_nettype wire

/* design/plme_ptr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module plme_ptr_regs
    import plme_pkg::*;
#(
    parameter int NPTR = 3
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Pointer access
    plme_ptr_if.regs pif
);
    logic [11:0] ptr_ff [NPTR];
    logic [11:0] nxt_ptr [NPTR];

    always_comb begin
        for (int i = 0; i < NPTR; i++) begin
            nxt_ptr[i] = ptr_ff[i];
            if (pif.sel == i[1:0]) begin
                if (pif.wr_hi) begin
                    nxt_ptr[i] = {pif.wdata[3:0], ptr_ff[i][7:0]};
                end
                if (pif.wr_lo) begin
                    nxt_ptr[i] = {ptr_ff[i][11:8], pif.wdata};
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        for (int i = 0; i < NPTR; i++) begin
            if (!nrst) begin
                ptr_ff[i] <= PTR_RST;
            end else begin
                ptr_ff[i] <= nxt_ptr[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NPTR; i++) begin
            pif.ptr[i] = ptr_ff[i];
        end
    end
endmodule
`default_nettype wire

/* design/plme_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module plme_exec
    import plme_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Fetched word, stable over the whole instruction cycle
    input wire logic [15:0] instr_word,
    // Core state used for addressing
    input wire logic [3:0] bank_select_register,
    input wire logic ext_set_en,
    // Data memory
    output logic [11:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // Architectural results
    output logic [7:0] w_reg,
    output logic [1:0] phase,
    output logic [11:0] ptr0,
    output logic [11:0] ptr1,
    output logic [11:0] ptr2
);
    plme_ptr_if pif ();
    plme_ptr_regs #(.NPTR(3)) u_ptr (
        .mclk(mclk),
        .nrst(nrst),
        .pif(pif)
    );
    plme_state_e st_ff, nxt_st;
    logic [1:0] q_ff, nxt_q;
    logic [11:0] addr_ff, nxt_addr;
    logic rd_ff, nxt_rd;
    logic wr_ff, nxt_wr;
    logic [7:0] wdata_ff, nxt_wdata;
    logic [7:0] w_ff, nxt_w;
    logic [7:0] data_ff, nxt_data;
    logic d_ff, nxt_d;
    logic src_w_ff, nxt_src_w;
    logic dst_w_ff, nxt_dst_w;
    logic phi_ff, nxt_phi;
    logic plo_ff, nxt_plo;
    logic [1:0] sel_ff, nxt_sel;
    logic [7:0] lit_ff, nxt_lit;
    logic is_lf, is_mv, is_ff;
    logic [11:0] mv_addr;
    logic [7:0] fa;
    assign is_lf = instr_word[15:6] == LF_OPC1;
    assign is_mv = instr_word[15:10] == MV_OPC;
    assign is_ff = instr_word[15:12] == FF_OPC1;
    assign fa = instr_word[7:0];

    // Effective address of a byte-oriented operand
    always_comb begin
        if (instr_word[8]) begin
            mv_addr = {bank_select_register, fa};
        end else if (ext_set_en && fa <= IDX_MAX) begin
            mv_addr = pif.ptr[2] + {4'h0, fa};
        end else if (fa < ACC_SPLIT) begin
            mv_addr = {ACC_LO_BANK, fa};
        end else begin
            mv_addr = {ACC_HI_BANK, fa};
        end
    end

    always_comb begin
        nxt_q = q_ff + 2'h1;
        nxt_st = st_ff;
        nxt_addr = addr_ff;
        nxt_rd = 1'b0;
        nxt_wr = 1'b0;
        nxt_wdata = wdata_ff;
        nxt_w = w_ff;
        nxt_data = data_ff;
        nxt_d = d_ff;
        nxt_src_w = src_w_ff;
        nxt_dst_w = dst_w_ff;
        nxt_phi = 1'b0;
        nxt_plo = 1'b0;
        nxt_sel = sel_ff;
        nxt_lit = lit_ff;
        unique case (st_ff)
            ST_IDLE: begin
                if (q_ff == Q1) begin
                    if (is_lf) begin
                        nxt_st = ST_LF1;
                        nxt_sel = instr_word[5:4];
                        nxt_lit = {4'h0, instr_word[3:0]};
                    end else if (is_mv) begin
                        nxt_st = ST_MV;
                        nxt_d = instr_word[9];
                        nxt_addr = mv_addr;
                        nxt_rd = 1'b1;
                    end else if (is_ff) begin
                        nxt_st = ST_FF1;
                        nxt_addr = instr_word[11:0];
                        nxt_src_w = instr_word[11:0] == WREG_ADDR;
                        nxt_rd = instr_word[11:0] != WREG_ADDR;
                    end
                end
            end
            ST_LF1: begin
                if (q_ff == Q3) begin
                    nxt_phi = sel_ff != PTR_SEL_BAD;
                end
                if (q_ff == Q4) begin
                    nxt_st = ST_LF2;
                end
            end
            ST_LF2: begin
                if (q_ff == Q1) begin
                    nxt_lit = instr_word[7:0];
                    // second word must carry its prefix
                    if (instr_word[15:8] != LF_OPC2) begin
                        nxt_st = ST_IDLE;
                    end
                end
                if (q_ff == Q3) begin
                    nxt_plo = sel_ff != PTR_SEL_BAD;
                end
                if (q_ff == Q4) begin
                    nxt_st = ST_IDLE;
                end
            end
            ST_MV: begin
                if (q_ff == Q2) begin
                    nxt_data = mem_rdata;
                end
                if (q_ff == Q3) begin
                    nxt_wr = d_ff;
                    nxt_wdata = data_ff;
                end
                if (q_ff == Q4) begin
                    if (!d_ff) begin
                        nxt_w = data_ff;
                    end
                    nxt_st = ST_IDLE;
                end
            end
            ST_FF1: begin
                if (q_ff == Q2) begin
                    nxt_data = src_w_ff ? w_ff : mem_rdata;
                end
                if (q_ff == Q4) begin
                    nxt_st = ST_FF2;
                end
            end
            ST_FF2: begin
                if (q_ff == Q1) begin
                    nxt_addr = instr_word[11:0];
                    nxt_dst_w = instr_word[11:0] == WREG_ADDR;
                    if (instr_word[15:12] != FF_OPC2) begin
                        nxt_st = ST_IDLE;
                    end
                end
                if (q_ff == Q3) begin
                    // destination written in Q4, no dummy read
                    nxt_wr = !dst_w_ff;
                    nxt_wdata = data_ff;
                end
                if (q_ff == Q4) begin
                    if (dst_w_ff) begin
                        nxt_w = data_ff;
                    end
                    nxt_st = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st_ff <= ST_IDLE;
            q_ff <= Q1;
            addr_ff <= ADDR_RST;
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            wdata_ff <= DATA_RST;
            w_ff <= W_RST;
            data_ff <= DATA_RST;
            d_ff <= 1'b0;
            src_w_ff <= 1'b0;
            dst_w_ff <= 1'b0;
            phi_ff <= 1'b0;
            plo_ff <= 1'b0;
            sel_ff <= 2'h0;
            lit_ff <= DATA_RST;
        end else begin
            st_ff <= nxt_st;
            q_ff <= nxt_q;
            addr_ff <= nxt_addr;
            rd_ff <= nxt_rd;
            wr_ff <= nxt_wr;
            wdata_ff <= nxt_wdata;
            w_ff <= nxt_w;
            data_ff <= nxt_data;
            d_ff <= nxt_d;
            src_w_ff <= nxt_src_w;
            dst_w_ff <= nxt_dst_w;
            phi_ff <= nxt_phi;
            plo_ff <= nxt_plo;
            sel_ff <= nxt_sel;
            lit_ff <= nxt_lit;
        end
    end

    // Pointer strobes are registered, so writes land at the end of Q4
    assign pif.wr_hi = phi_ff;
    assign pif.wr_lo = plo_ff;
    assign pif.sel = sel_ff;
    assign pif.wdata = lit_ff;

    assign mem_addr = addr_ff;
    assign mem_rd = rd_ff;
    assign mem_wr = wr_ff;
    assign mem_wdata = wdata_ff;
    assign w_reg = w_ff;
    assign phase = q_ff;
    assign ptr0 = pif.ptr[0];
    assign ptr1 = pif.ptr[1];
    assign ptr2 = pif.ptr[2];

    property p_rd_q2;
        @(posedge mclk) disable iff (!nrst) rd_ff |-> q_ff == Q2;
    endproperty
    a_rd_q2: assert property (p_rd_q2) else $error("read outside Q2");
    property p_wr_q4;
        @(posedge mclk) disable iff (!nrst) wr_ff |-> q_ff == Q4;
    endproperty
    a_wr_q4: assert property (p_wr_q4) else $error("write outside Q4");
    property p_lf_hi;
        @(posedge mclk) disable iff (!nrst)
        (st_ff == ST_IDLE && q_ff == Q1 && is_lf
            && instr_word[5:4] != PTR_SEL_BAD)
        |-> ##4 pif.ptr[sel_ff][11:8] == $past(instr_word[3:0], 4);
    endproperty
    a_lf_hi: assert property (p_lf_hi) else $error("ptr high wrong");
    property p_lf_lo;
        @(posedge mclk) disable iff (!nrst)
        (st_ff == ST_LF2 && q_ff == Q1 && instr_word[15:8] == LF_OPC2
            && sel_ff != PTR_SEL_BAD)
        |-> ##4 pif.ptr[sel_ff][7:0] == $past(instr_word[7:0], 4);
    endproperty
    a_lf_lo: assert property (p_lf_lo) else $error("pointer low wrong");
    property p_mv_w;
        @(posedge mclk) disable iff (!nrst)
        (st_ff == ST_IDLE && q_ff == Q1 && is_mv && !instr_word[9])
        |-> ##2 (w_ff == $past(w_ff)) ##2 w_ff == $past(mem_rdata, 3);
    endproperty
    a_mv_w: assert property (p_mv_w) else $error("move to W wrong");
    property p_mv_bank;
        @(posedge mclk) disable iff (!nrst)
        (st_ff == ST_IDLE && q_ff == Q1 && is_mv && instr_word[8])
        |=> rd_ff && addr_ff == {$past(bank_select_register), $past(fa)};
    endproperty
    a_mv_bank: assert property (p_mv_bank) else $error("bank wrong");
    property p_mv_idx;
        @(posedge mclk) disable iff (!nrst)
        (st_ff == ST_IDLE && q_ff == Q1 && is_mv && !instr_word[8]
            && ext_set_en && fa <= IDX_MAX)
        |=> addr_ff == $past(pif.ptr[2]) + {4'h0, $past(fa)};
    endproperty
    a_mv_idx: assert property (p_mv_idx) else $error("idx addr wrong");
    property p_ff_dst;
        @(posedge mclk) disable iff (!nrst)
        (st_ff == ST_FF2 && q_ff == Q1 && instr_word[15:12] == FF_OPC2
            && instr_word[11:0] != WREG_ADDR)
        |-> !rd_ff [*3] ##1 wr_ff && addr_ff == $past(instr_word[11:0], 3)
            && wdata_ff == data_ff;
    endproperty
    a_ff_dst: assert property (p_ff_dst) else $error("copy wr wrong");
    property p_ff_wdst;
        @(posedge mclk) disable iff (!nrst)
        (st_ff == ST_FF2 && q_ff == Q1 && instr_word[15:12] == FF_OPC2
            && instr_word[11:0] == WREG_ADDR)
        |-> ##4 w_ff == $past(data_ff) && !$past(wr_ff);
    endproperty
    a_ff_wdst: assert property (p_ff_wdst) else $error("W copy wrong");
endmodule
`default_nettype wire

/* tb/plme_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module plme_mem_model (
    // Clock
    input wire logic mclk,
    // Data memory port
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [4096];
    logic [7:0] junk;

    initial begin
        junk = 8'h00;
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i) ^ {4'(i >> 8), 4'(i >> 8)};
        end
    end

    always @(posedge mclk) begin
        junk <= junk + 8'h35;
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    // Undriven read bus keeps changing so stale data is never trusted
    assign mem_rdata = mem_rd ? mem[mem_addr] : junk;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(48'(g), 48'(e));
module tb_top;
    localparam logic [1:0] KLF = 2'h0;
    localparam logic [1:0] KMW = 2'h1;
    localparam logic [1:0] KMF = 2'h2;
    localparam logic [1:0] KFF = 2'h3;
    typedef struct packed {
        logic [1:0] kind;
        logic [15:0] w1;
        logic [15:0] w2;
        logic [3:0] bank;
        logic ext;
        logic [11:0] ra;
        logic [11:0] wa;
        logic [11:0] ev;
    } plme_row_s;
    logic mclk, nrst, ext_set_en, mem_rd, mem_wr;
    logic [15:0] instr_word;
    logic [3:0] bank_select_register;
    logic [11:0] mem_addr, ptr0, ptr1, ptr2;
    logic [7:0] mem_wdata, mem_rdata, w_reg;
    logic [1:0] phase;
    int err_total, n_checks;
    plme_row_s rows [13];

    plme_exec i_plme_exec (.mclk(mclk), .nrst(nrst),
        .instr_word(instr_word),
        .bank_select_register(bank_select_register),
        .ext_set_en(ext_set_en), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .w_reg(w_reg), .phase(phase), .ptr0(ptr0), .ptr1(ptr1),
        .ptr2(ptr2));
    plme_mem_model i_plme_mem_model (.mclk(mclk), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    function automatic logic [7:0] iv(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], a[11:8]};
    endfunction

    function automatic logic [11:0] ptr_of(input logic [11:0] s);
        return s == 12'h000 ? ptr0 : (s == 12'h001 ? ptr1 : ptr2);
    endfunction

    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic tick();
        @(posedge mclk);
        #1;
    endtask

    // Words change only at the start of Q1 and stay for the whole cycle
    task automatic put_word(input logic [15:0] w);
        do tick(); while (phase !== 2'h0);
        instr_word = w;
    endtask

    task automatic run_row(input plme_row_s r);
        bank_select_register = r.bank;
        ext_set_en = r.ext;
        put_word(r.w1);
        tick();
        if (r.kind != KLF) begin
            `CHK({mem_rd, mem_addr}, {1'b1, r.ra})
        end
        tick();
        tick();
        if (r.kind == KMF) begin
            `CHK({mem_wr, mem_addr, mem_wdata}, {1'b1, r.wa, r.ev[7:0]})
        end
        put_word(r.w2);
        if (r.kind == KMW) begin
            `CHK(w_reg, r.ev)
        end
        if (r.kind == KFF) begin
            tick();
            `CHK(mem_rd, 1'b0)
            tick();
            `CHK(mem_rd, 1'b0)
            tick();
            `CHK({mem_wr, mem_addr, mem_wdata}, {1'b1, r.wa, r.ev[7:0]})
        end
        if (r.kind == KLF) begin
            put_word(16'h0000);
            `CHK(ptr_of(r.wa), r.ev)
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // About 190 cycles are needed; 10000 means a hang
    initial begin
        #100000;
        err_total++;
        results();
    end

    initial begin
        nrst = 1'b0;
        instr_word = 16'h0000;
        bank_select_register = 4'h0;
        ext_set_en = 1'b0;
        err_total = 0;
        n_checks = 0;
        rows[0] = '{KLF, 16'hee03, 16'hf0ab, 4'h0, 1'b0, 0, 0, 12'h3ab};
        rows[1] = '{KLF, 16'hee1f, 16'hf0ff, 4'h0, 1'b0, 0, 1, 12'hfff};
        rows[2] = '{KLF, 16'hee20, 16'hf020, 4'h0, 1'b0, 0, 2, 12'h020};
        rows[3] = '{KMW, 16'h5145, 0, 4'h3, 1'b0, 12'h345, 0, iv(12'h345)};
        rows[4] = '{KMW, 16'h5010, 0, 4'h3, 1'b0, 12'h010, 0, iv(12'h010)};
        rows[5] = '{KMW, 16'h5090, 0, 4'h3, 1'b0, 12'hf90, 0, iv(12'hf90)};
        rows[6] = '{KMW, 16'h5020, 0, 4'h3, 1'b1, 12'h040, 0, iv(12'h040)};
        rows[7] = '{KMW, 16'h505f, 0, 4'h3, 1'b1, 12'h07f, 0, iv(12'h07f)};
        rows[8] = '{KMW, 16'h5060, 0, 4'h3, 1'b1, 12'h060, 0, iv(12'h060)};
        rows[9] = '{KMF, 16'h5307, 0, 4'ha, 1'b0, 12'ha07, 12'ha07,
            iv(12'ha07)};
        // copies never aim at program counter or stack top bytes
        rows[10] = '{KFF, 16'hc123, 16'hf456, 4'h0, 1'b0, 12'h123, 12'h456,
            iv(12'h123)};
        rows[11] = '{KFF, 16'hc000, 16'hffff, 4'h0, 1'b0, 12'h000, 12'hfff,
            iv(12'h000)};
        rows[12] = '{KMW, 16'h5156, 0, 4'h4, 1'b0, 12'h456, 0, iv(12'h123)};
        repeat (2) @(posedge mclk);
        #1;
        nrst = 1'b1;
        `CHK({ptr0, ptr1, ptr2, w_reg, mem_rd, mem_wr, phase}, 0)
        foreach (rows[i]) run_row(rows[i]);
        put_word(16'hee0c);
        put_word(16'hf051);
        `CHK(ptr0, 12'hcab)
        put_word(16'hee3a);
        `CHK(ptr0, 12'hc51)
        put_word(16'hf055);
        put_word(16'hee05);
        put_word(16'hf1aa);
        put_word(16'h0000);
        // High nibble lands before the bad second word is seen
        `CHK({ptr0, ptr1, ptr2}, {12'h551, 12'hfff, 12'h020})
        put_word(16'hcffe);
        tick();
        `CHK(mem_rd, 1'b0)
        put_word(16'hf300);
        repeat (3) tick();
        `CHK({mem_wr, mem_addr, mem_wdata}, {1'b1, 12'h300, 8'h32})
        put_word(16'hc0a5);
        put_word(16'hfffe);
        repeat (3) tick();
        `CHK(mem_wr, 1'b0)
        put_word(16'hc010);
        `CHK(w_reg, iv(12'h0a5))
        put_word(16'he011);
        repeat (3) tick();
        `CHK(mem_wr, 1'b0)
        // Reset in mid-load drops the load and clears all state
        put_word(16'hee05);
        tick();
        nrst = 1'b0;
        instr_word = 16'h0000;
        repeat (2) tick();
        `CHK({ptr0, ptr1, ptr2, w_reg, mem_rd, mem_wr, phase}, 0)
        nrst = 1'b1;
        put_word(16'hee21);
        put_word(16'hf034);
        put_word(16'h0000);
        `CHK(ptr2, 12'h134)
        results();
    end
endmodule
`default_nettype wire
